// [hw/psd_top.sv]
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Function
// RQ1: Eight 32-bit thresholds, zero disables detector
// RQ2: Nonzero threshold counts one per picosecond
// RQ3: Flag violation when phase transient exceeds threshold
// RQ4: Detector idle unless channel frequency locked
// RQ5: Runs continuously while reference stays active
// RQ6: Fault bit clear: violation only restarts acquisition
// RQ7: Fault bit set: also reset reference monitor
// RQ8: Restart uses fast acquisition, buildout or slew
// RQ9: Live status plus latched bit per channel
// RQ10: Software clears latched bit to see more
// RQ11: Intentional offsets or skew may also trigger
// RQ12: Software limits slew to (threshold+freq)/7
// RQ13: Software sets threshold above twice rms jitter
// RQ14: Software forces fault for known external switches
// RQ15: Eight signed 24-bit skews, zero disables
// RQ16: Nonzero skew applied to associated reference
// RQ17: Compare sample magnitude with active profile threshold
module psd_top import psd_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [PSD_ADDR_W-1:0] reg_addr_i,
  input wire logic [PSD_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [PSD_DATA_W-1:0] reg_rdata_o,
  input wire psd_sample_t [PSD_NUM_CH-1:0] chan_sample_i,
  output psd_action_t [PSD_NUM_CH-1:0] chan_action_o,
  output psd_skew_t [PSD_NUM_CH-1:0] chan_skew_o,
  output logic [PSD_NUM_CH-1:0] step_live_o,
  output logic irq_o
);

  // Register state of the top level, all but the reset synchroniser
  typedef struct packed {
    logic [PSD_NUM_PROF-1:0][PSD_THR_W-1:0] thr;
    logic [PSD_NUM_PROF-1:0][PSD_SKEW_W-1:0] skew;
    logic [PSD_NUM_CH-1:0] fault_en;
    logic [PSD_NUM_CH-1:0] irq_sts;
    logic [PSD_NUM_CH-1:0] irq_mask;
    logic [PSD_NUM_CH-1:0][PSD_CNT_W-1:0] vcnt;
    psd_skew_t [PSD_NUM_CH-1:0] skew_out;
    logic [PSD_DATA_W-1:0] rdata;
    logic irq;
  } psd_top_state_t;

  psd_top_state_t q, d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [PSD_NUM_CH-1:0][PSD_THR_W-1:0] chan_thr;
  logic [PSD_NUM_CH-1:0][PSD_THR_W-1:0] chan_mag;
  psd_action_t [PSD_NUM_CH-1:0] chan_act;
  logic [PSD_NUM_CH-1:0] chan_live;

  // True when addr selects entry idx of a word array starting at base
  function automatic logic word_hit(
    input logic [PSD_ADDR_W-1:0] addr,
    input logic [PSD_ADDR_W-1:0] base,
    input int unsigned idx
  );
    logic [PSD_ADDR_W-1:0] ofs;
    ofs = base + PSD_ADDR_W'(idx) * PSD_OFS_STRIDE;
    return addr == ofs;
  endfunction

  // Sign-extend a profile skew to a bus word
  function automatic logic [PSD_DATA_W-1:0] skew_word(
    input logic [PSD_SKEW_W-1:0] s
  );
    return {{(PSD_DATA_W-PSD_SKEW_W){s[PSD_SKEW_W-1]}}, s};
  endfunction

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // One comparator per channel, fed from its active source profile
  for (genvar c = 0; c < PSD_NUM_CH; c++) begin : g_chan
    assign chan_thr[c] = q.thr[chan_sample_i[c].profile]; // [RQ17]

    psd_chan u_chan (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .sample_i(chan_sample_i[c]),
      .threshold_i(chan_thr[c]),
      .fault_en_i(q.fault_en[c]),
      .action_o(chan_act[c]),
      .live_o(chan_live[c]),
      .mag_o(chan_mag[c])
    );
  end

  // Register writes, latched events, counters and read data
  always_comb begin
    d = q;
    d.rdata = '0;

    // Profile tables
    for (int p = 0; p < PSD_NUM_PROF; p++) begin
      if (reg_wr_i && word_hit(reg_addr_i, PSD_OFS_THR_BASE, p)) begin
        d.thr[p] = reg_wdata_i; // [RQ1]
      end
      if (reg_wr_i && word_hit(reg_addr_i, PSD_OFS_SKEW_BASE, p)) begin
        d.skew[p] = reg_wdata_i[PSD_SKEW_W-1:0]; // [RQ15]
      end
    end

    // Per-channel control, counters and latched step bits
    for (int c = 0; c < PSD_NUM_CH; c++) begin
      if (reg_wr_i && word_hit(reg_addr_i, PSD_OFS_CTRL_BASE, c)) begin
        d.fault_en[c] = reg_wdata_i[PSD_CTRL_FAULT_EN_BIT]; // [RQ7]
      end
      // Any write clears the violation counter of that channel, unless a violation in the same cycle counts on from the old value
      if (reg_wr_i && word_hit(reg_addr_i, PSD_OFS_VCNT_BASE, c)) begin
        d.vcnt[c] = '0;
      end
      // Write one to clear; the status stays set until then
      if (reg_wr_i && (reg_addr_i == PSD_OFS_IRQ_STS)
          && reg_wdata_i[c]) begin
        d.irq_sts[c] = 1'b0; // [RQ10]
      end
      // A new event in the clear cycle wins so it is not lost
      if (chan_act[c].acq_restart) begin
        d.irq_sts[c] = 1'b1; // [RQ9]
        // Saturate rather than wrap so a long burst never reads back as a small count
        if (q.vcnt[c] != PSD_CNT_MAX) begin
          d.vcnt[c] = q.vcnt[c] + 16'h0001;
        end
      end
      // Skew follows the profile that the channel is using
      d.skew_out[c].value = q.skew[chan_sample_i[c].profile]; // [RQ16]
      d.skew_out[c].en =
        (q.skew[chan_sample_i[c].profile] != PSD_SKEW_RST); // [RQ15]
    end

    if (reg_wr_i && (reg_addr_i == PSD_OFS_IRQ_MASK)) begin
      d.irq_mask = reg_wdata_i[PSD_NUM_CH-1:0];
    end

    // Level interrupt from unmasked latched bits, one cycle behind
    d.irq = |(q.irq_sts & q.irq_mask);

    // Read data stands only in the cycle after the strobe
    if (reg_rd_i) begin
      for (int p = 0; p < PSD_NUM_PROF; p++) begin
        if (word_hit(reg_addr_i, PSD_OFS_THR_BASE, p)) begin
          d.rdata = q.thr[p];
        end
        if (word_hit(reg_addr_i, PSD_OFS_SKEW_BASE, p)) begin
          d.rdata = skew_word(q.skew[p]);
        end
      end
      for (int c = 0; c < PSD_NUM_CH; c++) begin
        if (word_hit(reg_addr_i, PSD_OFS_CTRL_BASE, c)) begin
          d.rdata[PSD_CTRL_FAULT_EN_BIT] = q.fault_en[c];
        end
        if (word_hit(reg_addr_i, PSD_OFS_VCNT_BASE, c)) begin
          d.rdata[PSD_CNT_W-1:0] = q.vcnt[c];
        end
        if (word_hit(reg_addr_i, PSD_OFS_VMAG_BASE, c)) begin
          d.rdata = chan_mag[c];
        end
      end
      if (reg_addr_i == PSD_OFS_LIVE) begin
        d.rdata[PSD_NUM_CH-1:0] = chan_live; // [RQ9]
      end
      if (reg_addr_i == PSD_OFS_IRQ_STS) begin
        d.rdata[PSD_NUM_CH-1:0] = q.irq_sts;
      end
      if (reg_addr_i == PSD_OFS_IRQ_MASK) begin
        d.rdata[PSD_NUM_CH-1:0] = q.irq_mask;
      end
    end
  end

  // Single state register; configuration reset values come from the package, counters, status and outputs reset to zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < PSD_NUM_PROF; p++) begin
        q.thr[p] <= PSD_THR_RST;
        q.skew[p] <= PSD_SKEW_RST;
      end
      for (int c = 0; c < PSD_NUM_CH; c++) begin
        q.fault_en[c] <= PSD_FAULT_EN_RST; // [RQ6]
        q.vcnt[c] <= '0;
        q.skew_out[c] <= '0;
      end
      q.irq_sts <= '0;
      q.irq_mask <= PSD_IRQ_MASK_RST;
      q.rdata <= '0;
      q.irq <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from flip-flops here or in the channels
  assign reg_rdata_o = q.rdata;
  assign chan_action_o = chan_act; // [RQ8]
  assign chan_skew_o = q.skew_out;
  assign step_live_o = chan_live;
  assign irq_o = q.irq;

endmodule // psd_top
`default_nettype wire

// [hw/psd_pkg.sv]
`default_nettype none
// Shared constants and carriers for the phase step detector block
package psd_pkg;

  // Structure sizes
  localparam int unsigned PSD_NUM_CH = 2;
  localparam int unsigned PSD_NUM_PROF = 8;
  localparam int unsigned PSD_PROF_W = 3;
  localparam int unsigned PSD_THR_W = 32;
  localparam int unsigned PSD_SKEW_W = 24;
  localparam int unsigned PSD_ERR_W = 32;
  localparam int unsigned PSD_CNT_W = 16;
  localparam int unsigned PSD_ADDR_W = 8;
  localparam int unsigned PSD_DATA_W = 32;

  // Register byte offsets (one aligned word each)
  localparam logic [7:0] PSD_OFS_THR_BASE = 8'h00;  // Profiles 0..7
  localparam logic [7:0] PSD_OFS_SKEW_BASE = 8'h20; // Profiles 0..7
  localparam logic [7:0] PSD_OFS_CTRL_BASE = 8'h40; // Channels 0..1
  localparam logic [7:0] PSD_OFS_LIVE = 8'h48;
  localparam logic [7:0] PSD_OFS_IRQ_STS = 8'h4C;
  localparam logic [7:0] PSD_OFS_IRQ_MASK = 8'h50;
  localparam logic [7:0] PSD_OFS_VCNT_BASE = 8'h54; // Channels 0..1
  localparam logic [7:0] PSD_OFS_VMAG_BASE = 8'h5C; // Channels 0..1
  localparam logic [7:0] PSD_OFS_STRIDE = 8'h04;

  // Field positions
  localparam int unsigned PSD_CTRL_FAULT_EN_BIT = 0;

  // Reset values
  localparam logic [31:0] PSD_THR_RST = 32'h0000_0000;
  localparam logic [23:0] PSD_SKEW_RST = 24'h00_0000;
  localparam logic PSD_FAULT_EN_RST = 1'h0;
  localparam logic [1:0] PSD_IRQ_MASK_RST = 2'h0;
  localparam logic [15:0] PSD_CNT_MAX = 16'hFFFF;

  // Phase detector sample from one pll channel
  typedef struct packed {
    logic valid;                    // One-cycle sample strobe
    logic freq_locked;              // Frequency lock detector state
    logic ref_active;               // Profiled reference is the active one
    logic [PSD_PROF_W-1:0] profile; // Active source profile index
    logic [PSD_ERR_W-1:0] err;      // Signed phase error in ps
  } psd_sample_t;

  // Actions toward the pll channel
  typedef struct packed {
    logic acq_restart;  // Start new acquisition
    logic refmon_reset; // Reset reference monitor statistics
  } psd_action_t;

  // Skew applied to the channel's reference input
  typedef struct packed {
    logic en;
    logic [PSD_SKEW_W-1:0] value; // Signed, ps
  } psd_skew_t;

endpackage
`default_nettype wire

// [hw/psd_chan.sv]
`timescale 1ns/1ns
`default_nettype none
// Per-channel phase transient comparator
module psd_chan import psd_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire psd_sample_t sample_i,
  input wire logic [PSD_THR_W-1:0] threshold_i,
  input wire logic fault_en_i,
  output psd_action_t action_o,
  output logic live_o,
  output logic [PSD_THR_W-1:0] mag_o
);

  typedef struct packed {
    psd_action_t act;
    logic live;
    logic [PSD_THR_W-1:0] mag;
  } psd_chan_state_t;

  psd_chan_state_t q, d;
  logic active;
  logic [PSD_THR_W-1:0] mag;
  logic viol;

  // Detector armed only when locked, on active ref, threshold nonzero
  assign active = sample_i.freq_locked // [RQ4]
                  && sample_i.ref_active // [RQ5]
                  && (threshold_i != PSD_THR_RST); // [RQ1]

  // Sign is dropped; the step size matters, not its direction
  assign mag = sample_i.err[PSD_ERR_W-1] ?
               (~sample_i.err + 32'h0000_0001) : sample_i.err; // [RQ17]

  // One count per ps on both sides, so a plain compare works
  // Skew or offset moves show up here like any other step
  assign viol = active && sample_i.valid
                && (mag > threshold_i); // [RQ2] [RQ3] [RQ11]

  // Next state
  always_comb begin
    d = q;
    d.act = '0;
    if (!active) begin
      d.live = 1'b0;
    end else if (sample_i.valid) begin
      d.live = viol; // [RQ9]
    end
    if (viol) begin
      d.act.acq_restart = 1'b1; // [RQ6] [RQ8]
      d.act.refmon_reset = fault_en_i; // [RQ7]
      d.mag = mag;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign action_o = q.act;
  assign live_o = q.live;
  assign mag_o = q.mag;

endmodule // psd_chan
`default_nettype wire

// [dv/psd_ref_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Phase detector sample source for one pll channel
module psd_ref_model import psd_pkg::*; (
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [PSD_ERR_W-1:0] err_i,
  input wire logic locked_i,
  input wire logic active_i,
  input wire logic [PSD_PROF_W-1:0] prof_i,
  output psd_sample_t sample_o
);
  initial sample_o = '0;
  // Error word keeps toggling between samples, so no stale value is reused
  always @(posedge clk_i) begin
    sample_o.valid <= fire_i;
    sample_o.err <= fire_i ? err_i : ~sample_o.err;
    sample_o.freq_locked <= locked_i;
    sample_o.ref_active <= active_i;
    sample_o.profile <= prof_i;
  end
endmodule // psd_ref_model
`default_nettype wire

// [dv/psd_top_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// Port-level checks; channel 0 in full, channel 1 for the lock gate
module psd_top_checker import psd_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire psd_sample_t [PSD_NUM_CH-1:0] chan_sample_i,
  input wire psd_action_t [PSD_NUM_CH-1:0] chan_action_o,
  input wire psd_skew_t [PSD_NUM_CH-1:0] chan_skew_o,
  input wire logic [PSD_NUM_CH-1:0] step_live_o
);
  // Short aliases keep the properties readable
  wire logic v0 = chan_sample_i[0].valid;
  wire logic l0 = chan_sample_i[0].freq_locked;
  wire logic a0 = chan_sample_i[0].ref_active;
  wire logic r0 = chan_action_o[0].acq_restart;
  wire logic m0 = chan_action_o[0].refmon_reset;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_armed0;
    v0 && l0 && a0;
  endsequence
  property p_lock0; !l0 |=> !r0; endproperty
  property p_lock1;
    !chan_sample_i[1].freq_locked |=> !chan_action_o[1].acq_restart;
  endproperty
  property p_active0; !a0 |=> !r0; endproperty
  property p_cause0; r0 |-> $past(v0 && l0 && a0); endproperty
  property p_pair0; m0 |-> r0; endproperty
  property p_skew0;
    chan_skew_o[0].en == (chan_skew_o[0].value != 24'h00_0000);
  endproperty
  property p_live0; s_armed0 ##1 r0 |-> step_live_o[0]; endproperty
  property p_quiet0; s_armed0 ##1 !r0 |-> !step_live_o[0]; endproperty
  property p_drop0; !l0 |=> !step_live_o[0]; endproperty
  a_lock0: assert property (p_lock0) else $error("restart while unlocked");
  a_lock1: assert property (p_lock1) else $error("ch1 restart unlocked");
  a_active0: assert property (p_active0) else $error("restart inactive");
  a_cause0: assert property (p_cause0) else $error("restart no sample");
  a_pair0: assert property (p_pair0) else $error("monitor reset alone");
  a_skew0: assert property (p_skew0) else $error("skew enable wrong");
  a_live0: assert property (p_live0) else $error("live not set");
  a_quiet0: assert property (p_quiet0) else $error("live without hit");
  a_drop0: assert property (p_drop0) else $error("live while unlocked");
endmodule // psd_top_checker
bind psd_top psd_top_checker u_chk (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .chan_sample_i(chan_sample_i),
  .chan_action_o(chan_action_o),
  .chan_skew_o(chan_skew_o),
  .step_live_o(step_live_o)
);
`default_nettype wire

// [dv/phase_step_detector_skew_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module phase_step_detector_skew_tb import psd_pkg::*;;
  logic clk = 1'b0;
  logic rst_n, wr, rd, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, seed, t;
  logic [1:0] fire, lck, act, live;
  logic [1:0][31:0] err;
  logic [1:0][2:0] prof;
  psd_sample_t [1:0] smp;
  psd_action_t [1:0] ao;
  psd_skew_t [1:0] skw;
  longint thr_m [8];
  bit [1:0] flt_m, sts_m, msk_m;
  int cnt_m [2];
  int error_cnt = 0;
  int checks = 0;
  psd_top u_dut (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .chan_sample_i(smp), .chan_action_o(ao), .chan_skew_o(skw),
    .step_live_o(live), .irq_o(irq));
  // One sample source per pll channel
  for (genvar c = 0; c < 2; c++) begin : g_ref
    psd_ref_model u_ref (.clk_i(clk), .fire_i(fire[c]), .err_i(err[c]),
      .locked_i(lck[c]), .active_i(act[c]), .prof_i(prof[c]),
      .sample_o(smp[c]));
  end
  // 125 MHz clock
  initial forever #4 clk = ~clk;
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data is looked at only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic hit(input int c, input int p, input logic [31:0] e);
    longint m;
    bit h;
    m = $signed(e);
    m = m < 0 ? -m : m;
    @(posedge clk);
    // Expectation is formed once lock and select changes have settled
    h = lck[c] && act[c] && thr_m[p] != 0 && m > thr_m[p];
    fire[c] <= 1'b1;
    err[c] <= e;
    prof[c] <= 3'(p);
    @(posedge clk);
    fire[c] <= 1'b0;
    @(posedge clk);
    #1 chk(ao[c].acq_restart, h);
    chk(ao[c].refmon_reset, h && flt_m[c]);
    chk(live[c], h);
    if (h) begin
      sts_m[c] = 1'b1;
      cnt_m[c]++;
    end
  endtask
  task automatic tend(input string s);
    $display("test %0s done", s);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {rst_n, wr, rd, addr, wdata, fire, err, prof} = '0;
    {lck, act, flt_m, sts_m, msk_m} = '0;
    thr_m = '{default: 0};
    cnt_m = '{default: 0};
    seed = 32'hEDD8A199;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int p = 0; p < 8; p++) begin
      rdc(PSD_OFS_THR_BASE + 8'(4 * p), 32'h0);
      rdc(PSD_OFS_SKEW_BASE + 8'(4 * p), 32'h0);
    end
    rdc(8'hFC, 32'h0);
    tend("reset");
    lck <= 2'h3;
    act <= 2'h3;
    hit(0, 1, 32'h7FFF_FFFF);
    // Channel 0 without and channel 1 with the monitor reset
    for (int c = 0; c < 2; c++) begin
      wrr(PSD_OFS_CTRL_BASE + 8'(4 * c), 32'(c));
      flt_m[c] = 1'(c);
      rdc(PSD_OFS_CTRL_BASE + 8'(4 * c), 32'(c));
      for (int p = 0; p < 8; p += 3) begin
        seed = lfsr(seed);
        // Nonzero thresholds below 2^24, each probed at and just past its own value
        t = {8'h00, seed[23:0]} | 32'h1;
        wrr(PSD_OFS_THR_BASE + 8'(4 * p), t);
        thr_m[p] = t;
        hit(c, p, t);
        hit(c, p, -t);
        hit(c, p, t + 32'h1);
        hit(c, p, -(t + 32'h1));
      end
    end
    wrr(PSD_OFS_THR_BASE + 8'h1C, 32'h7FFF_FFFF);
    thr_m[7] = 32'h7FFF_FFFF;
    hit(0, 7, 32'h7FFF_FFFF);
    hit(0, 7, 32'h8000_0000);
    lck[0] <= 1'b0;
    hit(0, 7, 32'h8000_0000);
    lck[0] <= 1'b1;
    // Deselecting the reference must keep the detector idle
    act[0] <= 1'b0;
    hit(0, 7, 32'h8000_0000);
    act[0] <= 1'b1;
    tend("detect");
    rdc(PSD_OFS_IRQ_STS, 32'(sts_m));
    chk(irq, 1'b0);
    wrr(PSD_OFS_IRQ_MASK, 32'h1);
    rdc(PSD_OFS_IRQ_MASK, 32'h1);
    chk(irq, 1'b1);
    wrr(PSD_OFS_IRQ_STS, 32'h1);
    rdc(PSD_OFS_IRQ_STS, 32'h2);
    chk(irq, 1'b0);
    hit(0, 7, 32'h8000_0000);
    rdc(PSD_OFS_IRQ_STS, 32'h3);
    chk(irq, 1'b1);
    rdc(PSD_OFS_VMAG_BASE, 32'h8000_0000);
    rdc(PSD_OFS_VCNT_BASE, 32'(cnt_m[0]));
    rdc(PSD_OFS_VCNT_BASE + 8'h04, 32'(cnt_m[1]));
    tend("irq");
    // Skew is changed with no sample in flight, so no slew trips
    wrr(PSD_OFS_SKEW_BASE + 8'h08, 32'h00FF_7748);
    rdc(PSD_OFS_SKEW_BASE + 8'h08, 32'hFFFF_7748);
    hit(1, 2, 32'h0);
    chk({skw[1].en, skw[1].value}, {1'b1, 24'hFF7748});
    hit(1, 4, 32'h0);
    chk({skw[1].en, skw[1].value}, 32'h0);
    tend("skew");
    give_verdict();
  end
endmodule // phase_step_detector_skew_tb
`default_nettype wire
